// >>> core/vector_interrupt_ctrl.sv
// Purpose: prioritised vectored interrupt controller with APB registers
// Assumes: pins synchronous-free inputs, synchronised here; APB zero wait
// Notes: timer a/b1, serial a, adc, direct events are one-cycle pulses;
//   timer x/v and serial b are levels whose flags live in the peripheral
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "vic_params.svh"

module vector_interrupt_ctrl (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [3:0] request_pins_in,
  input wire logic [7:0] edge_interrupt_pins_in,
  input wire vic_pkg::periph_req_s periph_req_in,
  input wire logic cpu_mask_in,
  input wire logic cpu_boundary_in,
  output logic cpu_irq_out,
  output vic_pkg::vector_t cpu_vector_out,
  output logic cpu_take_out,
  output logic irq_out
);

  // ************************************************************
  // bus decode
  // ************************************************************
  logic acc;
  logic wr;
  logic rd;
  logic [15:0] idx;
  logic idx_ok;
  logic hit;

  assign idx = paddr_in[17:2];
  assign idx_ok = (paddr_in[31:18] == 14'h0000) && (paddr_in[1:0] == 2'h0);
  assign acc = psel_in && penable_in;
  assign hit = idx_ok && (idx >= `IDX_REQ_EDGE) && (idx <= `IDX_EVT_MASK);
  assign wr = acc && pwrite_in && hit;
  assign rd = acc && !pwrite_in && hit;
  assign pready_out = 1'b1;
  assign pslverr_out = acc && !hit;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] req_edge_q;
  logic [7:0] pin_edge_q;
  logic [7:0] en_first_q;
  logic [7:0] en_second_q;
  logic [7:0] en_third_q;
  logic [7:0] flg_first_q;
  logic [7:0] flg_second_q;
  logic [7:0] flg_third_q;
  logic [7:0] flg_first_d;
  logic [7:0] flg_second_d;
  logic [7:0] flg_third_d;
  logic [7:0] evt_status_q;
  logic [7:0] evt_status_d;
  logic [7:0] evt_mask_q;
  logic [7:0] wd;

  assign wd = pwdata_in[7:0];

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      req_edge_q <= `RST_REQ_EDGE;
    else if (wr && idx == `IDX_REQ_EDGE)
      req_edge_q <= (wd & `WM_REQ_EDGE) | (`RST_REQ_EDGE & ~`WM_REQ_EDGE);
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      pin_edge_q <= `RST_PIN_EDGE;
    else if (wr && idx == `IDX_PIN_EDGE)
      pin_edge_q <= wd;
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      en_first_q <= `RST_EN_FIRST;
      en_second_q <= `RST_EN_SECOND;
      en_third_q <= `RST_EN_THIRD;
    end
    else if (wr)
    begin
      if (idx == `IDX_EN_FIRST)
        en_first_q <= (wd & `WM_EN_FIRST) | (`RST_EN_FIRST & ~`WM_EN_FIRST);
      if (idx == `IDX_EN_SECOND)
        en_second_q <= wd & `WM_EN_SECOND;
      if (idx == `IDX_EN_THIRD)
        en_third_q <= wd;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      evt_mask_q <= 8'h00;
    else if (wr && idx == `IDX_EVT_MASK)
      evt_mask_q <= wd & 8'h07;
  end

  // ************************************************************
  // pin synchronisers and edge detection
  // ************************************************************
  logic [11:0] pin_raw;
  logic [11:0] sync1_q;
  logic [11:0] sync2_q;
  logic [11:0] prev_q;
  logic [11:0] edge_sel;
  logic [11:0] pin_edge;

  assign pin_raw = {edge_interrupt_pins_in, request_pins_in};
  assign edge_sel = {pin_edge_q, req_edge_q[3:0]};

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      sync1_q <= 12'hFFF;
      sync2_q <= 12'hFFF;
      prev_q <= 12'hFFF;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++)
    begin : g_edge
      assign pin_edge[gi] = edge_sel[gi] ? (sync2_q[gi] && !prev_q[gi])
                                         : (!sync2_q[gi] && prev_q[gi]);
    end
  endgenerate

  // ************************************************************
  // request flags
  // ************************************************************
  logic [7:0] set_first;
  logic [7:0] set_second;
  logic [7:0] clr_first;
  logic [7:0] clr_second;
  logic [7:0] clr_third;

  // each pulse source its own flag bit; timer x/v and serial b have none
  always_comb
  begin
    set_first = {4'h0, pin_edge[3:0]};
    set_first[`BIT_TIMER_A] = periph_req_in.timer_a;
    set_first[`BIT_TIMER_B1] = periph_req_in.timer_b1;
    set_second = 8'h00;
    set_second[`BIT_DIRECT] = periph_req_in.direct;
    set_second[`BIT_ADC] = periph_req_in.adc;
    set_second[`BIT_SERIAL_A] = periph_req_in.serial_a;
  end

  assign clr_first = (wr && idx == `IDX_FLG_FIRST) ? (~wd & `WM_FLG_FIRST) : 8'h00;
  assign clr_second = (wr && idx == `IDX_FLG_SECOND) ? (~wd & `WM_FLG_SECOND) : 8'h00;
  assign clr_third = (wr && idx == `IDX_FLG_THIRD) ? ~wd : 8'h00;

  // set wins over a clear in the same cycle
  assign flg_first_d = (flg_first_q & ~clr_first) | set_first;
  assign flg_second_d = (flg_second_q & ~clr_second) | set_second;
  assign flg_third_d = (flg_third_q & ~clr_third) | pin_edge[11:4];

  // flags latch regardless of cpu mask
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      flg_first_q <= `RST_FLG_FIRST;
      flg_second_q <= `RST_FLG_SECOND;
      flg_third_q <= `RST_FLG_THIRD;
    end
    else
    begin
      flg_first_q <= flg_first_d;
      flg_second_q <= flg_second_d;
      flg_third_q <= flg_third_d;
    end
  end

  // ************************************************************
  // event status, cleared by read
  // ************************************************************
  logic [7:0] evt_set;

  always_comb
  begin
    evt_set = 8'h00;
    evt_set[`EVT_REQ_PIN] = |pin_edge[3:0];
    evt_set[`EVT_EDGE_PIN] = |pin_edge[11:4];
    evt_set[`EVT_INTERNAL] = |(set_first[7:6]) || |(set_second);
    if (rd && idx == `IDX_EVT_STATUS)
      evt_status_d = (evt_status_q & ~prdata_out[7:0]) | evt_set;
    else
      evt_status_d = evt_status_q | evt_set;
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      evt_status_q <= 8'h00;
    else
      evt_status_q <= evt_status_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(evt_status_d & evt_mask_q);
  end

  // ************************************************************
  // read data
  // ************************************************************
  logic [7:0] rmux;

  always_comb
  begin
    rmux = 8'h00;
    unique case (idx)
      `IDX_REQ_EDGE: rmux = req_edge_q;
      `IDX_PIN_EDGE: rmux = pin_edge_q;
      `IDX_EN_FIRST: rmux = en_first_q;
      `IDX_EN_SECOND: rmux = en_second_q;
      `IDX_EN_THIRD: rmux = en_third_q;
      `IDX_FLG_FIRST: rmux = flg_first_q;
      `IDX_FLG_SECOND: rmux = flg_second_q;
      `IDX_FLG_THIRD: rmux = flg_third_q;
      `IDX_EVT_STATUS: rmux = evt_status_q;
      `IDX_EVT_MASK: rmux = evt_mask_q;
      default: rmux = 8'h00;
    endcase
  end

  // loaded at setup so it stands at the access edge; a status read
  // clears only the bits this snapshot reported, so no event is lost
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      prdata_out <= 32'h0000_0000;
    else if (psel_in && !penable_in)
      prdata_out <= {24'h00_0000, rmux};
  end

  // ************************************************************
  // pending and priority
  // ************************************************************
  logic [3:0] pend_req;
  logic pend_edge;
  logic pend_ta;
  logic pend_tb;
  logic pend_tx;
  logic pend_tv;
  logic pend_sa;
  logic pend_sb;
  logic pend_adc;
  logic pend_dt;
  logic any_pend;
  vic_pkg::vector_t win_vec;

  assign pend_req = flg_first_q[3:0] & en_first_q[3:0] & {4{!cpu_mask_in}};
  assign pend_edge = |(flg_third_q & en_third_q) && !cpu_mask_in;
  assign pend_ta = flg_first_q[`BIT_TIMER_A] && en_first_q[`BIT_TIMER_A] && !cpu_mask_in;
  assign pend_tb = flg_first_q[`BIT_TIMER_B1] && en_first_q[`BIT_TIMER_B1] && !cpu_mask_in;
  assign pend_tx = |periph_req_in.timer_x && !cpu_mask_in;
  assign pend_tv = |periph_req_in.timer_v && !cpu_mask_in;
  assign pend_sa = flg_second_q[`BIT_SERIAL_A] && en_second_q[`BIT_SERIAL_A] && !cpu_mask_in;
  assign pend_sb = |periph_req_in.serial_b && !cpu_mask_in;
  assign pend_adc = flg_second_q[`BIT_ADC] && en_second_q[`BIT_ADC] && !cpu_mask_in;
  assign pend_dt = flg_second_q[`BIT_DIRECT] && en_second_q[`BIT_DIRECT] && !cpu_mask_in;

  assign any_pend = |pend_req || pend_edge || pend_ta || pend_tb || pend_tx ||
                    pend_tv || pend_sa || pend_sb || pend_adc || pend_dt;

  always_comb
  begin
    win_vec = `VEC_DIRECT;
    if (pend_req[0])
      win_vec = `VEC_REQ_PIN0;
    else if (pend_req[1])
      win_vec = 5'(`VEC_REQ_PIN0 + 5'h01);
    else if (pend_req[2])
      win_vec = 5'(`VEC_REQ_PIN0 + 5'h02);
    else if (pend_req[3])
      win_vec = 5'(`VEC_REQ_PIN0 + 5'h03);
    else if (pend_edge)
      win_vec = `VEC_EDGE_PINS;
    else if (pend_ta)
      win_vec = `VEC_TIMER_A;
    else if (pend_tb)
      win_vec = `VEC_TIMER_B1;
    else if (pend_tx)
      win_vec = `VEC_TIMER_X;
    else if (pend_tv)
      win_vec = `VEC_TIMER_V;
    else if (pend_sa)
      win_vec = `VEC_SERIAL_A;
    else if (pend_sb)
      win_vec = `VEC_SERIAL_B;
    else if (pend_adc)
      win_vec = `VEC_ADC;
  end

  // ************************************************************
  // cpu presentation
  // ************************************************************
  vic_pkg::run_state_e run_q;

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      run_q <= vic_pkg::ST_RESET_HOLD;
    else if (run_q == vic_pkg::ST_RESET_HOLD && cpu_boundary_in)
      run_q <= vic_pkg::ST_RUN;
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      cpu_irq_out <= 1'b0;
      cpu_vector_out <= 5'h00;
    end
    else
    begin
      cpu_irq_out <= any_pend && (run_q == vic_pkg::ST_RUN);
      cpu_vector_out <= (any_pend && run_q == vic_pkg::ST_RUN) ? win_vec : 5'h00;
    end
  end

  assign cpu_take_out = cpu_irq_out && cpu_boundary_in && !cpu_mask_in;

endmodule // vector_interrupt_ctrl

// >>> core/vic_params.svh
// Purpose: constants for the vectored interrupt controller
// Assumes: each register has an index; its byte address is index*4
// Notes: definitions only
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH

// register indices
`define IDX_REQ_EDGE 16'hFFF2
`define IDX_PIN_EDGE 16'hFFF3
`define IDX_EN_FIRST 16'hFFF4
`define IDX_EN_SECOND 16'hFFF5
`define IDX_EN_THIRD 16'hFFF6
`define IDX_FLG_FIRST 16'hFFF7
`define IDX_FLG_SECOND 16'hFFF8
`define IDX_FLG_THIRD 16'hFFF9
`define IDX_EVT_STATUS 16'hFFFA
`define IDX_EVT_MASK 16'hFFFB

// reset values
`define RST_REQ_EDGE 8'h70
`define RST_PIN_EDGE 8'h00
`define RST_EN_FIRST 8'h10
`define RST_EN_SECOND 8'h00
`define RST_EN_THIRD 8'h00
`define RST_FLG_FIRST 8'h10
`define RST_FLG_SECOND 8'h00
`define RST_FLG_THIRD 8'h00

// writable bits; the rest keep their fixed value
`define WM_REQ_EDGE 8'h0F
`define WM_EN_FIRST 8'hCF
`define WM_EN_SECOND 8'hD0
`define WM_FLG_FIRST 8'hCF
`define WM_FLG_SECOND 8'hD0

// field positions in first and second enable/flag registers
`define BIT_TIMER_B1 7
`define BIT_TIMER_A 6
`define BIT_DIRECT 7
`define BIT_ADC 6
`define BIT_SERIAL_A 4

// event status bits
`define EVT_REQ_PIN 0
`define EVT_EDGE_PIN 1
`define EVT_INTERNAL 2

// vector numbers
`define VEC_REQ_PIN0 5'h04
`define VEC_EDGE_PINS 5'h08
`define VEC_TIMER_A 5'h0A
`define VEC_TIMER_B1 5'h0B
`define VEC_TIMER_X 5'h10
`define VEC_TIMER_V 5'h11
`define VEC_SERIAL_A 5'h13
`define VEC_SERIAL_B 5'h15
`define VEC_ADC 5'h16
`define VEC_DIRECT 5'h17

`endif

// >>> core/vic_pkg.sv
// Purpose: types for the vectored interrupt controller
// Assumes: nothing
// Notes: constants live in vic_params.svh
package vic_pkg;

  typedef logic [4:0] vector_t;

  // internal peripheral request lines
  typedef struct packed {
    logic timer_a;
    logic timer_b1;
    logic [6:0] timer_x;
    logic [2:0] timer_v;
    logic serial_a;
    logic [5:0] serial_b;
    logic adc;
    logic direct;
  } periph_req_s;

  typedef enum logic [1:0] {
    ST_RESET_HOLD,
    ST_RUN
  } run_state_e;

endpackage

// >>> test/cpu_model.sv
// Purpose: cpu side: mask bit and instruction boundaries
// Assumes: mask request from bench
// Notes: gap sets boundary spacing
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic mask_req_in,
  input wire logic [1:0] gap_in,
  output logic cpu_mask_out,
  output logic cpu_boundary_out
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      cnt_q <= 2'h0;
      cpu_boundary_out <= 1'b0;
    end
    else
    begin
      cpu_boundary_out <= (cnt_q == gap_in);
      cnt_q <= (cnt_q == gap_in) ? 2'h0 : cnt_q + 2'h1;
    end
  end
  // masked out of reset, as after reset handling
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      cpu_mask_out <= 1'b1;
    else
      cpu_mask_out <= mask_req_in;
  end
endmodule // cpu_model

// >>> test/vectored_interrupt_controller_bench.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: cpu_model drives mask and boundary
// Notes: seeded random pins, selects and sources
`timescale 1ns/1ps
module vectored_interrupt_controller_bench;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] paddr_in = 32'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [3:0] request_pins_in = 4'hF;
  logic [7:0] edge_interrupt_pins_in = 8'hFF;
  vic_pkg::periph_req_s periph_req_in = '0;
  logic cpu_mask_in;
  logic cpu_boundary_in;
  logic cpu_irq_out;
  vic_pkg::vector_t cpu_vector_out;
  logic cpu_take_out;
  logic irq_out;
  logic mask_req = 1'b1;
  logic [1:0] gap = 2'h1;
  logic [31:0] rdat;
  logic serr;
  int err_count = 0;
  int n_checks = 0;
  always #10 clk_in = ~clk_in;
  vector_interrupt_ctrl i_dut (.clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .request_pins_in,
    .edge_interrupt_pins_in, .periph_req_in, .cpu_mask_in, .cpu_boundary_in,
    .cpu_irq_out, .cpu_vector_out, .cpu_take_out, .irq_out);
  cpu_model i_cpu (.clk_in, .reset_n_in, .mask_req_in(mask_req), .gap_in(gap),
    .cpu_mask_out(cpu_mask_in), .cpu_boundary_out(cpu_boundary_in));
  // ****
  // helpers
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [15:0] i, input logic w, input logic [7:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {14'h0000, i, 2'b00};
    pwdata_in <= {24'h000000, d};
    tick(1);
    penable_in <= 1'b1;
    // no own limit: only the watchdog ends a stuck access
    do
    begin
      tick(1);
    end
    while (pready_out !== 1'b1);
    rdat = prdata_out;
    serr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] e, input string nm);
    xfer(i, 1'b0, 8'h00);
    chk(nm, {24'h000000, e}, rdat);
  endtask
  task automatic clr;
    xfer(16'hFFF7, 1'b1, 8'h00);
    xfer(16'hFFF8, 1'b1, 8'h00);
    xfer(16'hFFF9, 1'b1, 8'h00);
    xfer(16'hFFFA, 1'b0, 8'h00);
    tick(2);
    chk("irq idle", 32'h0, 32'(cpu_irq_out));
  endtask
  task automatic wait_vec(input logic [4:0] v);
    int n;
    n = 0;
    while (cpu_irq_out !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk("irq presented", 32'h1, 32'(cpu_irq_out));
    chk("vector", 32'(v), 32'(cpu_vector_out));
  endtask
  // lowest set pin wins
  function automatic logic [4:0] pin_vec(input logic [3:0] p);
    for (int b = 3; b >= 0; b--)
      if (p[b])
        pin_vec = 5'h04 + 5'(b);
  endfunction
  task automatic summarize;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    int k;
    logic [3:0] p;
    vic_pkg::periph_req_s pr;
    logic [7:0] rv [8];
    logic [7:0] wv [8];
    logic [4:0] iv [9];
    rv = '{8'h70, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
    wv = '{8'h7F, 8'hFF, 8'hDF, 8'hD0, 8'hFF, 8'h10, 8'h00, 8'h00};
    iv = '{5'h0A, 5'h0B, 5'h10, 5'h11, 5'h13, 5'h15, 5'h16, 5'h17, 5'h16};
    rdat = $urandom(32'h36A3015A);
    tick(8);
    reset_n_in <= 1'b1;
    tick(1);
    for (k = 0; k < 8; k++)
    begin
      rd(16'hFFF2 + 16'(k), rv[k], "reset value");
      xfer(16'hFFF2 + 16'(k), 1'b1, 8'hFF);
      rd(16'hFFF2 + 16'(k), wv[k], "written value");
    end
    xfer(16'hFFFC, 1'b0, 8'h00);
    chk("unmapped error", 32'h1, 32'(serr));
    xfer(16'hFFF2, 1'b1, 8'h00);
    xfer(16'hFFF3, 1'b1, 8'h00);
    xfer(16'hFFF4, 1'b1, 8'h00);
    mask_req <= 1'b0;
    request_pins_in <= 4'hE;
    tick(8);
    chk("irq disabled", 32'h0, 32'(cpu_irq_out));
    rd(16'hFFF7, 8'h11, "flag");
    mask_req <= 1'b1;
    xfer(16'hFFF4, 1'b1, 8'h01);
    tick(4);
    chk("irq masked", 32'h0, 32'(cpu_irq_out));
    mask_req <= 1'b0;
    wait_vec(5'h04);
    request_pins_in <= 4'hF;
    clr();
    xfer(16'hFFF4, 1'b1, 8'hCF);
    xfer(16'hFFF5, 1'b1, 8'hD0);
    xfer(16'hFFF6, 1'b1, 8'hFF);
    for (k = 0; k < 4; k++)
    begin
      gap <= 2'($urandom);
      xfer(16'hFFF2, 1'b1, 8'h01 << k);
      request_pins_in[k] <= 1'b0;
      tick(6);
      chk("wrong edge", 32'h0, 32'(cpu_irq_out));
      request_pins_in[k] <= 1'b1;
      wait_vec(5'h04 + 5'(k));
      clr();
      p = 4'($urandom % 15) + 4'h1;
      xfer(16'hFFF2, 1'b1, 8'h00);
      request_pins_in <= ~p;
      wait_vec(pin_vec(p));
      // pins back high before the clear, so their rising edges pass
      // while sensing is still falling and cannot set a flag later
      request_pins_in <= 4'hF;
      clr();
    end
    for (k = 0; k < 8; k++)
    begin
      xfer(16'hFFF3, 1'b1, 8'($urandom) & ~(8'h01 << k));
      edge_interrupt_pins_in[k] <= 1'b0;
      wait_vec(5'h08);
      rd(16'hFFF9, 8'h01 << k, "edge flag");
      edge_interrupt_pins_in[k] <= 1'b1;
      clr();
    end
    for (k = 0; k < 9; k++)
    begin
      pr = '0;
      case (k)
        0: pr.timer_a = 1'b1;
        1: pr.timer_b1 = 1'b1;
        2: pr.timer_x = 7'h01 << ($urandom % 7);
        3: pr.timer_v = 3'h1 << ($urandom % 3);
        4: pr.serial_a = 1'b1;
        5: pr.serial_b = 6'h01 << ($urandom % 6);
        6: pr.adc = 1'b1;
        7: pr.direct = 1'b1;
        default: {pr.adc, pr.direct} = 2'b11;
      endcase
      periph_req_in <= pr;
      tick(1);
      if (k < 2 || k == 4 || k > 5)
        periph_req_in <= '0;
      wait_vec(iv[k]);
      periph_req_in <= '0;
      clr();
    end
    xfer(16'hFFFB, 1'b1, 8'h05);
    periph_req_in.adc <= 1'b1;
    tick(1);
    periph_req_in.adc <= 1'b0;
    tick(2);
    chk("irq_out raised", 32'h1, 32'(irq_out));
    rd(16'hFFFA, 8'h04, "event status");
    chk("irq_out cleared", 32'h0, 32'(irq_out));
    // edge loop left pin 0 sensing random; make it falling again
    xfer(16'hFFF3, 1'b1, 8'h00);
    edge_interrupt_pins_in[0] <= 1'b0;
    tick(8);
    chk("irq_out masked", 32'h0, 32'(irq_out));
    rd(16'hFFFA, 8'h02, "masked status");
    // mid-run reset with a source pending and mask clear: nothing may
    // be presented before the first boundary
    gap <= 2'h3;
    edge_interrupt_pins_in[0] <= 1'b1;
    periph_req_in.timer_x <= 7'h01;
    reset_n_in <= 1'b0;
    tick(2);
    reset_n_in <= 1'b1;
    tick(3);
    chk("irq before boundary", 32'h0, 32'(cpu_irq_out));
    wait_vec(5'h10);
    periph_req_in <= '0;
    summarize();
  end
  initial
  begin
    tick(20000);
    err_count++;
    summarize();
  end
endmodule // vectored_interrupt_controller_bench

// >>> test/vic_sva.sv
// Purpose: port checks for the interrupt controller
// Assumes: zero-wait apb, registered cpu irq and vector outputs
// Notes: bind at foot
`timescale 1ns/1ps
`include "vic_params.svh"
module vic_sva (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic cpu_mask_in,
  input wire logic cpu_boundary_in,
  input wire logic cpu_irq_out,
  input wire vic_pkg::vector_t cpu_vector_out,
  input wire logic cpu_take_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic seen_q;
  logic rd;
  assign rd = psel_in && penable_in && !pwrite_in;
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      seen_q <= 1'b0;
    else if (cpu_boundary_in)
      seen_q <= 1'b1;
  end
  property p_take;
    cpu_take_out == (cpu_irq_out && cpu_boundary_in && !cpu_mask_in);
  endproperty
  a_take: assert property (p_take) else $error("take pulse wrong");
  property p_mask;
    cpu_mask_in |=> !cpu_irq_out;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_vec;
    cpu_irq_out |-> cpu_vector_out inside {5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A,
      5'h0B, 5'h10, 5'h11, 5'h13, 5'h15, 5'h16, 5'h17};
  endproperty
  a_vec: assert property (p_vec) else $error("illegal vector");
  property p_idle;
    !cpu_irq_out |-> cpu_vector_out == 5'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("vector without irq");
  property p_first;
    !seen_q |-> !cpu_irq_out;
  endproperty
  a_first: assert property (p_first) else $error("irq before boundary");
  property p_rise;
    $rose(cpu_irq_out) |-> $past(!cpu_mask_in);
  endproperty
  a_rise: assert property (p_rise) else $error("irq rose while masked");
  property p_fixed;
    rd && paddr_in == {14'h0000, `IDX_REQ_EDGE, 2'b00} |-> prdata_out[7:4] == 4'h7;
  endproperty
  a_fixed: assert property (p_fixed) else $error("edge select fixed bits");
  property p_en;
    rd && paddr_in == {14'h0000, `IDX_EN_FIRST, 2'b00} |-> prdata_out[5:4] == 2'b01;
  endproperty
  a_en: assert property (p_en) else $error("enable fixed bits");
  c_take: cover property (cpu_take_out);
  c_edge: cover property (cpu_irq_out && cpu_vector_out == 5'h08);
  c_mask: cover property (cpu_mask_in ##1 !cpu_mask_in ##[1:8] cpu_irq_out);
endmodule // vic_sva
bind vector_interrupt_ctrl vic_sva i_sva (.clk_in, .reset_n_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .prdata_out, .cpu_mask_in, .cpu_boundary_in, .cpu_irq_out,
  .cpu_vector_out, .cpu_take_out);
